// *** hw/gbo_pkg.sv ***
// Register map, field positions and reset values of the port bit-operate block.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package gbo_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_EVENT_ROUTE = 8'h00;
   localparam logic [7:0] OFF_SET_CLEAR = 8'h10;
   localparam logic [7:0] OFF_BIT_CLEAR = 8'h14;
   localparam logic [7:0] OFF_LOCK = 8'h18;
   localparam logic [7:0] OFF_MODE_LO = 8'h20;
   localparam logic [7:0] OFF_MODE_HI = 8'h24;
   localparam logic [7:0] OFF_OUT_LATCH = 8'h28;
   localparam logic [7:0] OFF_HIGH_SPEED = 8'h3c;
   localparam int LOCK_KEY_POS = 16;
   localparam int EV_ENABLE_POS = 7;
   localparam int EV_PORT_LSB = 4;
   localparam int EV_PIN_LSB = 0;
   localparam logic [2:0] EV_PORT_LAST = 3'h4;
   localparam logic [31:0] RESET_ZERO = 32'h00000000;
   localparam logic [1:0] MODE_VERY_HIGH = 2'h3;
   typedef enum logic [2:0] {KEY_IDLE, KEY_W1, KEY_W0, KEY_W1B, KEY_R0} gbo_key_e;
endpackage : gbo_pkg

// *** hw/gbo_port.sv ***
// Port bit-operate block: set/clear latch, configuration lock, speed select,
// event output routing onto one pin of five ports.
// Assumes an Avalon-MM master in the clk domain, word transfers only.
`timescale 1ns/1ps
`default_nettype none
module gbo_port #(
   parameter int PINS = 16, // Pins per port
   parameter int PORTS = 5 // Ports served by event routing
) (
   input wire logic clk, // 100 MHz clock
   input wire logic rst_n, // Sync reset, active low
   input wire logic [7:0] address, // Byte address
   input wire logic read, // Read request
   input wire logic write, // Write request
   input wire logic [31:0] writedata, // Write data
   input wire logic [3:0] byteenable, // Byte lanes
   output logic [31:0] readdata, // Read data
   output logic waitrequest, // Stall, high until answered
   input wire logic processorEvent, // Processor event signal
   output logic [PINS-1:0] pinOut, // Output latch to pins
   output logic [2*PINS-1:0] pinMode, // Two-bit mode per pin
   output logic [2*PINS-1:0] pinConfig, // Two-bit configuration per pin
   output logic [PINS-1:0] pinVeryHighSpeed, // Very high speed per pin
   output logic [PORTS*PINS-1:0] eventPinOut, // Event level per port pin
   output logic [PORTS*PINS-1:0] eventPinSel // Pin taken by event output
);
   ////////////////////////////////////////////////////////////////////////
   logic [PINS-1:0] outputLatch;
   logic [PINS-1:0] pinLockBit;
   logic lockKeyBit;
   logic [PINS-1:0] highSpeed;
   logic [7:0] eventRoute;
   logic [4*PINS-1:0] modeCfg; // {cfg,mode} nibble per pin
   gbo_pkg::gbo_key_e keyState;
   logic ack;
   logic wrStb;
   logic rdStb;
   logic [31:0] next_readdata;

   // One-wait-state handshake: ack on second cycle of request
   assign wrStb = write && ack;
   assign rdStb = read && ack;

   function automatic logic isWord(input logic [3:0] be);
      isWord = (be == 4'hf);
   endfunction : isWord

   // Event route decode for one port pin
   function automatic logic routeHit(input logic [7:0] route, input int q, input int p);
      routeHit = route[gbo_pkg::EV_ENABLE_POS] &&
         route[gbo_pkg::EV_PORT_LSB +: 3] == 3'(q) &&
         route[gbo_pkg::EV_PIN_LSB +: 4] == 4'(p);
   endfunction : routeHit

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (read || write) && !ack;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && !ack);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output latch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outputLatch <= gbo_pkg::RESET_ZERO[PINS-1:0];
      end else if (wrStb && address == gbo_pkg::OFF_SET_CLEAR) begin
         // Clear first, then set overrides
         outputLatch <= (outputLatch & ~writedata[31:16]) | writedata[15:0];
      end else if (wrStb && address == gbo_pkg::OFF_BIT_CLEAR && isWord(byteenable)) begin
         outputLatch <= outputLatch & ~writedata[15:0];
      end else if (wrStb && address == gbo_pkg::OFF_OUT_LATCH) begin
         outputLatch <= writedata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lock key sequence
   logic lockWr;
   logic lockRd;
   assign lockWr = wrStb && address == gbo_pkg::OFF_LOCK;
   assign lockRd = rdStb && address == gbo_pkg::OFF_LOCK;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         keyState <= gbo_pkg::KEY_IDLE;
         lockKeyBit <= 1'b0;
      end else if (!lockKeyBit) begin
         if (lockWr) begin
            // Lock bits changing mid-sequence abort it
            case (keyState)
               gbo_pkg::KEY_IDLE: keyState <= writedata[gbo_pkg::LOCK_KEY_POS] ?
                  gbo_pkg::KEY_W1 : gbo_pkg::KEY_IDLE;
               gbo_pkg::KEY_W1: keyState <= (!writedata[gbo_pkg::LOCK_KEY_POS] &&
                  writedata[15:0] == pinLockBit) ? gbo_pkg::KEY_W0 : gbo_pkg::KEY_IDLE;
               gbo_pkg::KEY_W0: keyState <= (writedata[gbo_pkg::LOCK_KEY_POS] &&
                  writedata[15:0] == pinLockBit) ? gbo_pkg::KEY_W1B : gbo_pkg::KEY_IDLE;
               default: keyState <= writedata[gbo_pkg::LOCK_KEY_POS] ?
                  gbo_pkg::KEY_W1 : gbo_pkg::KEY_IDLE;
            endcase
         end else if (lockRd) begin
            case (keyState)
               gbo_pkg::KEY_W1B: keyState <= gbo_pkg::KEY_R0;
               gbo_pkg::KEY_R0: begin
                  keyState <= gbo_pkg::KEY_IDLE;
                  lockKeyBit <= 1'b1;
               end
               default: keyState <= gbo_pkg::KEY_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinLockBit <= gbo_pkg::RESET_ZERO[PINS-1:0];
      end else if (lockWr && !lockKeyBit) begin
         pinLockBit <= writedata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode and configuration, frozen per locked pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         modeCfg <= '0;
      end else if (wrStb && (address == gbo_pkg::OFF_MODE_LO ||
                             address == gbo_pkg::OFF_MODE_HI)) begin
         for (int p = 0; p < 8; p++) begin
            if (!(lockKeyBit && pinLockBit[p + (address[2] ? 8 : 0)])) begin
               modeCfg[4*(p + (address[2] ? 8 : 0)) +: 4] <= writedata[4*p +: 4];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int p = 0; p < PINS; p++) begin
         pinMode[2*p +: 2] <= rst_n ? modeCfg[4*p +: 2] : 2'h0;
         pinConfig[2*p +: 2] <= rst_n ? modeCfg[4*p+2 +: 2] : 2'h0;
         pinVeryHighSpeed[p] <= rst_n && highSpeed[p] &&
            modeCfg[4*p +: 2] == gbo_pkg::MODE_VERY_HIGH;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         highSpeed <= gbo_pkg::RESET_ZERO[PINS-1:0];
      end else if (wrStb && address == gbo_pkg::OFF_HIGH_SPEED && isWord(byteenable)) begin
         highSpeed <= writedata[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinOut <= '0;
      end else begin
         pinOut <= outputLatch;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event output routing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eventRoute <= gbo_pkg::RESET_ZERO[7:0];
      end else if (wrStb && address == gbo_pkg::OFF_EVENT_ROUTE && isWord(byteenable)) begin
         eventRoute <= writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      for (int q = 0; q < PORTS; q++) begin
         for (int p = 0; p < PINS; p++) begin
            eventPinSel[q*PINS+p] <= rst_n && routeHit(eventRoute, q, p);
            eventPinOut[q*PINS+p] <= rst_n && routeHit(eventRoute, q, p) &&
               processorEvent;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; write-only registers read zero
   // Final key read of the sequence already returns the key as set
   logic keyPreview;
   assign keyPreview = lockKeyBit || (read && keyState == gbo_pkg::KEY_R0);

   always_comb begin
      next_readdata = 32'h00000000;
      case (address)
         gbo_pkg::OFF_EVENT_ROUTE: next_readdata = {24'h000000, eventRoute};
         gbo_pkg::OFF_LOCK: next_readdata = {15'h0000, keyPreview, pinLockBit};
         gbo_pkg::OFF_HIGH_SPEED: next_readdata = {16'h0000, highSpeed};
         gbo_pkg::OFF_OUT_LATCH: next_readdata = {16'h0000, outputLatch};
         gbo_pkg::OFF_MODE_LO: next_readdata = modeCfg[31:0];
         gbo_pkg::OFF_MODE_HI: next_readdata = modeCfg[63:32];
         default: next_readdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readdata <= 32'h00000000;
      end else if (read && !ack) begin
         readdata <= next_readdata;
      end
   end
endmodule : gbo_port
`default_nettype wire

// *** sim/gbo_port_checker.sv ***
// Checker for bus timing, latch updates, event routing and lock.
// Assumes gbo_port ports only; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module gbo_port_checker #(parameter int PINS = 16, parameter int PORTS = 5) (
   input wire logic clk, rst_n, read, write, waitrequest, processorEvent,
   input wire logic [7:0] address,
   input wire logic [31:0] writedata, readdata,
   input wire logic [3:0] byteenable,
   input wire logic [PINS-1:0] pinOut, pinVeryHighSpeed,
   input wire logic [2*PINS-1:0] pinMode, pinConfig,
   input wire logic [PORTS*PINS-1:0] eventPinOut, eventPinSel);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
logic [31:0] lastWd, lockVal;
logic [PINS-1:0] prevOut, topMode;
logic [2*PINS-1:0] lockMask;
logic keyed;
wire wTake = write && !waitrequest;
wire rTake = read && !waitrequest;
always_ff @(posedge clk) begin
   if (wTake) begin
      lastWd <= writedata;
      prevOut <= pinOut;
   end
end
always_ff @(posedge clk) begin
   if (!rst_n) keyed <= 1'b0;
   else if (rTake && address == gbo_pkg::OFF_LOCK && readdata[16]) keyed <= 1'b1;
end
always_ff @(posedge clk) begin
   if (!keyed && rTake && address == gbo_pkg::OFF_LOCK) lockVal <= readdata;
end
always_comb begin
   for (int p = 0; p < PINS; p++) begin
      topMode[p] = &pinMode[2*p +: 2];
      lockMask[2*p +: 2] = {2{lockVal[p]}};
   end
end
a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("late answer");
a_set_clear: assert property (wTake && address == gbo_pkg::OFF_SET_CLEAR
   |=> ##1 pinOut == ((prevOut & ~lastWd[31:16]) | lastWd[15:0])) else $error("set/clear");
a_bit_clear: assert property (wTake && address == gbo_pkg::OFF_BIT_CLEAR && byteenable == 4'hf
   |=> ##1 pinOut == (prevOut & ~lastWd[15:0])) else $error("bit clear");
a_route_pick: assert property (wTake && address == 8'h00 && byteenable == 4'hf
   |=> ##1 lastWd[6:4] > 3'h4 || eventPinSel == (lastWd[7] ?
   80'h1 << (lastWd[6:4] * 16 + lastWd[3:0]) : 80'h0)) else $error("route select");
a_sel_onehot: assert property ($onehot0(eventPinSel)) else $error("select not one-hot");
a_event_level: assert property ($stable(eventPinSel) |-> eventPinOut ==
   (eventPinSel & {PORTS*PINS{$past(processorEvent)}})) else $error("event level");
a_speed_mode: assert property ((pinVeryHighSpeed & ~(topMode | $past(topMode))) == 0)
   else $error("speed without mode");
a_key_sticky: assert property (rTake && address == gbo_pkg::OFF_LOCK && keyed
   |-> readdata == lockVal) else $error("lock changed");
a_lock_freeze: assert property (keyed |-> ((pinMode ^ $past(pinMode)) & lockMask) == 0
   && ((pinConfig ^ $past(pinConfig)) & lockMask) == 0) else $error("locked pin changed");
a_reset_zero: assert property (disable iff (1'b0) !rst_n |=> waitrequest && pinOut == 0
   && eventPinSel == 0 && pinVeryHighSpeed == 0) else $error("reset state");
c_key: cover property (keyed && rTake);
c_route: cover property (wTake && address == gbo_pkg::OFF_EVENT_ROUTE);
c_clear: cover property (wTake && address == gbo_pkg::OFF_SET_CLEAR);
endmodule : gbo_port_checker
bind gbo_port gbo_port_checker #(.PINS(PINS), .PORTS(PORTS)) i_chk (.clk, .rst_n, .read,
   .write, .waitrequest, .processorEvent, .address, .writedata, .readdata, .byteenable,
   .pinOut, .pinVeryHighSpeed, .pinMode, .pinConfig, .eventPinOut, .eventPinSel);
`default_nettype wire

// *** sim/gbo_pin_load.sv ***
// Pads of the first port: event route overrides the latch.
// Assumes port 0 sits in the low sixteen event bits.
`timescale 1ns/1ps
`default_nettype none
module gbo_pin_load (
   input wire logic [15:0] latchLevel, // Latch drive
   input wire logic [15:0] evLevel, // Event drive
   input wire logic [15:0] evSel, // Event pick
   output logic [15:0] padLevel // Pad level
);
   assign padLevel = (latchLevel & ~evSel) | (evLevel & evSel);
endmodule : gbo_pin_load
`default_nettype wire

// *** sim/gbo_port_tb.sv ***
// Self-checking bench with a bench model of latch, route and lock.
// Assumes gbo_port, gbo_pin_load and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module gbo_port_tb;
logic clk, rst_n, read, write, processorEvent, waitrequest;
logic [7:0] address;
logic [31:0] writedata, readdata, r, d, e, got, pinMode, pinConfig;
logic [3:0] byteenable;
logic [15:0] pinOut, vhs, pad;
logic [79:0] evOut, evSel;
logic [7:0] offs[5] = '{8'h00, 8'h18, 8'h3c, 8'h10, 8'h40};
int fail_count, checks, mOut;
gbo_port i_dut (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
   .waitrequest, .processorEvent, .pinOut, .pinMode, .pinConfig, .pinVeryHighSpeed(vhs),
   .eventPinOut(evOut), .eventPinSel(evSel));
gbo_pin_load i_load (.latchLevel(pinOut), .evLevel(evOut[15:0]), .evSel(evSel[15:0]),
   .padLevel(pad));
function automatic logic [31:0] lfsr(input logic [31:0] x);
   return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction : lfsr
function automatic logic [15:0] fld(input logic [31:0] x, input int o);
   for (int p = 0; p < 8; p++) fld[2*p +: 2] = x[4*p + o +: 2];
endfunction : fld
task automatic chk(input logic [79:0] g, input logic [79:0] x);
   checks++;
   if (g !== x) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
   end
endtask : chk
task automatic print_verdict();
   $display("checks %0d fail_count %0d", checks, fail_count);
   if (fail_count == 0 && checks > 0) $display("Result: passed");
   else $display("Result: failed");
   $finish;
endtask : print_verdict
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
   int n;
   @(posedge clk);
   address <= a;
   writedata <= dat;
   write <= w;
   read <= !w;
   n = 0;
   do begin
      @(posedge clk);
      n++;
   end while (waitrequest !== 1'b0 && n < 20);
   got = readdata;
   if (n >= 20) begin
      fail_count++;
      print_verdict();
   end
   write <= 1'b0;
   read <= 1'b0;
endtask : bus
initial begin
   clk = 1'b0;
   forever #5 clk = ~clk;
end
always @(posedge clk) begin
   r = lfsr(r);
   processorEvent <= r[7];
end
initial begin
   r = 32'h0ca422c8;
   {rst_n, read, write, processorEvent, address, writedata} = '0;
   byteenable = 4'hf;
   {fail_count, checks, mOut} = '0;
   repeat (10) @(posedge clk);
   rst_n <= 1'b1;
   foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      chk(got, 0);
   end
   for (int i = 0; i < 12; i++) begin
      d = r;
      bus(1'b1, i[0] ? 8'h14 : 8'h10, d);
      mOut = i[0] ? mOut & ~d[15:0] : (mOut & ~d[31:16]) | d[15:0];
      repeat (2) @(posedge clk);
      chk(pad, mOut);
   end
   byteenable <= 4'h3;
   bus(1'b1, 8'h14, 32'hffff);
   byteenable <= 4'hf;
   repeat (2) @(posedge clk);
   chk(pad, mOut);
   for (int p = 0; p < 5; p++) begin
      d = {24'h0, 1'b1, p[2:0], p == 4 ? 4'hf : r[3:0]};
      bus(1'b1, 8'h00, d);
      bus(1'b0, 8'h00, 32'h0);
      chk(got, d);
      chk(evSel, 80'h1 << (p * 16 + d[3:0]));
   end
   bus(1'b1, 8'h00, 32'h0);
   repeat (2) @(posedge clk);
   chk(evSel, 80'h0);
   bus(1'b1, 8'h3c, 32'hffff);
   d = r;
   bus(1'b1, 8'h20, d);
   repeat (3) @(posedge clk);
   for (int p = 0; p < 8; p++) chk(vhs[p], &d[4*p +: 2]);
   bus(1'b1, 8'h18, 32'h100ff);
   bus(1'b0, 8'h18, 32'h0);
   chk(got, 32'hff);
   bus(1'b1, 8'h18, 32'h100ff);
   bus(1'b1, 8'h18, 32'h000ff);
   bus(1'b1, 8'h18, 32'h100ff);
   bus(1'b0, 8'h18, 32'h0);
   chk(got, 32'hff);
   bus(1'b0, 8'h18, 32'h0);
   chk(got, 32'h100ff);
   bus(1'b1, 8'h18, 32'h0);
   bus(1'b0, 8'h18, 32'h0);
   chk(got, 32'h100ff);
   e = r;
   bus(1'b1, 8'h20, ~d);
   bus(1'b1, 8'h24, e);
   repeat (2) @(posedge clk);
   chk(pinMode, {fld(e, 0), fld(d, 0)});
   chk(pinConfig, {fld(e, 2), fld(d, 2)});
   print_verdict();
end
endmodule : gbo_port_tb
`default_nettype wire
